// ==== src/qcil_pkg.sv ====
package qcil_pkg;

    // ************************************************************
    // Unit dimensions
    // ************************************************************
    localparam int NUM_CH     = 6;
    localparam int NUM_MATCH  = 4;      // Match sources per channel slot (A..D)
    localparam int NUM_PHASE  = 4;      // Phase-counting channels 1, 2, 4, 5
    localparam int NUM_MIRQ   = 16;     // Total match interrupts
    localparam int CNT_W      = 16;

    // Match slot indices
    localparam int SLOT_A     = 0;
    localparam int SLOT_B     = 1;
    localparam int SLOT_C     = 2;
    localparam int SLOT_D     = 3;

    // Slots that exist per channel (channels 0 and 3 have four)
    localparam logic [NUM_CH*NUM_MATCH-1:0] MATCH_PRESENT = 24'h33F33F;
    // Channels with an underflow source
    localparam logic [NUM_CH-1:0] UNDF_PRESENT = 6'h36;
    // Channels on pin pair 1
    localparam logic [NUM_CH-1:0] PAIR1_CH     = 6'h22;

    // Counter range ends
    localparam logic [CNT_W-1:0] CNT_MAX   = 16'hFFFF;
    localparam logic [CNT_W-1:0] CNT_MIN   = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;

    // Phase counting mode selection
    typedef enum logic [1:0] {
        QCIL_MODE_OFF,
        QCIL_MODE_2,
        QCIL_MODE_3,
        QCIL_MODE_4
    } qcil_mode_t;

endpackage

// ==== src/qcil_phase_dec.sv ====
`timescale 1ns/100ps
// One phase decoder: synchroniser, edge detect, count, flags
module qcil_phase_dec
    import qcil_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             pha,
    input  wire logic             phb,
    input  wire logic [1:0]       mode,
    output logic      [CNT_W-1:0] count,
    output logic                  dir_down,
    output logic                  ovf_evt,
    output logic                  unf_evt,
    output logic                  clk_evt
);

    logic [1:0]       a_sync_q;
    logic [1:0]       b_sync_q;
    logic             a_prev_q;
    logic             b_prev_q;
    logic             a_rise, a_fall, b_rise, b_fall;
    logic             up, dn;
    logic [CNT_W-1:0] cnt_q;
    logic             dir_q;
    logic             ovf_q;
    logic             unf_q;
    logic             cev_q;
    qcil_mode_t       md;

    assign md = qcil_mode_t'(mode);

    // Two-stage synchronisers on both phases
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            a_sync_q <= 2'h0;
            b_sync_q <= 2'h0;
        end else begin
            a_sync_q <= {a_sync_q[0], pha};
            b_sync_q <= {b_sync_q[0], phb};
        end
    end

    // Previous synchronised level for edge detect
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            a_prev_q <= 1'b0;
            b_prev_q <= 1'b0;
        end else begin
            a_prev_q <= a_sync_q[1];
            b_prev_q <= b_sync_q[1];
        end
    end

    assign a_rise = a_sync_q[1] & ~a_prev_q;
    assign a_fall = ~a_sync_q[1] & a_prev_q;
    assign b_rise = b_sync_q[1] & ~b_prev_q;
    assign b_fall = ~b_sync_q[1] & b_prev_q;

    // Up/down decode per mode
    always_comb begin
        up = 1'b0;
        dn = 1'b0;
        unique case (md)
            QCIL_MODE_OFF: up = 1'b0;
            QCIL_MODE_2: begin
                up = a_fall & b_sync_q[1];
                dn = a_fall & ~b_sync_q[1];
            end
            QCIL_MODE_3: begin
                up = a_fall & b_sync_q[1];
                dn = b_fall & a_sync_q[1];
            end
            QCIL_MODE_4: begin
                up = (b_rise & a_sync_q[1]) | (b_fall & ~a_sync_q[1]);
                dn = (b_fall & a_sync_q[1]) | (b_rise & ~a_sync_q[1]);
            end
        endcase
    end

    // Counter clocked by phase edges only, no prescaler path
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= CNT_RESET;
        end else if (up) begin
            cnt_q <= cnt_q + 16'h0001;
        end else if (dn) begin
            cnt_q <= cnt_q - 16'h0001;
        end
    end

    // Direction, wrap events and count-clock pulse
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dir_q <= 1'b0;
            ovf_q <= 1'b0;
            unf_q <= 1'b0;
            cev_q <= 1'b0;
        end else begin
            if (up)
                dir_q <= 1'b0;
            else if (dn)
                dir_q <= 1'b1;
            ovf_q <= up & (cnt_q == CNT_MAX);
            unf_q <= dn & (cnt_q == CNT_MIN);
            cev_q <= up | dn;
        end
    end

    assign count    = cnt_q;
    assign dir_down = dir_q;
    assign ovf_evt  = ovf_q;
    assign unf_evt  = unf_q;
    assign clk_evt  = cev_q;

endmodule // qcil_phase_dec

// ==== src/qcil_flag.sv ====
`timescale 1ns/100ps
// One sticky status flag with enable-gated request
module qcil_flag (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic set_evt,
    input  wire logic clr,
    input  wire logic en,
    output logic      flag,
    output logic      req
);

    logic flag_q;

    // Set wins over clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            flag_q <= 1'b0;
        else if (set_evt)
            flag_q <= 1'b1;
        else if (clr)
            flag_q <= 1'b0;
    end

    assign flag = flag_q;
    assign req  = flag_q & en;

endmodule // qcil_flag

// ==== src/qcil_top.sv ====
`timescale 1ns/100ps
// Summary of operation
// - Channels 1 and 5 use pin pair 1; channels 2 and 4 use pair 2.
// - Mode 2 counts on A falling edge; B high up, B low down.
// - Mode 3: A falling edge with B high up; B falling edge with A high down.
// - Mode 4: only B edges count; direction from A level and edge polarity.
// - Three source kinds: match, overflow, underflow, each with flag and enable.
// - Event sets its flag; request asserted only while enable is also set.
// - Request drops as soon as its flag is cleared; no acknowledge.
// - Priority within a channel is fixed in hardware; channel order external.
// - Sixteen match interrupts: four on channels 0 and 3, two elsewhere.
// - Each of six channels has one overflow interrupt.
// - Underflow interrupts only on channels 1, 2, 4 and 5.
// - Only match interrupts may activate the transfer engine.
// - Register-A match flag set with trigger enable sends conversion start.
// - One conversion-start source per channel, from register-A match only.
// - Channel 1 count clock may serve as channel 0 register-B capture trigger.
// - Channel 0 A and C matches may capture channel 1 registers A and B.
// - Phase counting uses phase inputs as clock, ignoring prescaler selection.
// - Overflow up sets overflow flag, underflow down sets underflow; direction flag.
// - Software clears flag by writing 0; transfer completion clears it too.
module qcil_top
    import qcil_pkg::*;
(
    input  wire logic                          MCLK,
    input  wire logic                          ARST_N,
    // Encoder pins
    input  wire logic                          PHASE_A_INPUT_P1,
    input  wire logic                          PHASE_B_INPUT_P1,
    input  wire logic                          PHASE_A_INPUT_P2,
    input  wire logic                          PHASE_B_INPUT_P2,
    // Mode per phase channel: index 0..3 = channel 1, 2, 4, 5
    input  wire logic [NUM_PHASE*2-1:0]        PHASE_MODE,
    // Events from the rest of the unit, slot index ch*4+slot
    input  wire logic [NUM_CH*NUM_MATCH-1:0]   MATCH_EVT,
    input  wire logic [NUM_CH-1:0]             OVF_EVT,
    input  wire logic [NUM_CH-1:0]             UNF_EVT,
    // Software clear strobes and enables
    input  wire logic [NUM_CH*NUM_MATCH-1:0]   MATCH_FLAG_CLR,
    input  wire logic [NUM_CH-1:0]             OVF_FLAG_CLR,
    input  wire logic [NUM_CH-1:0]             UNF_FLAG_CLR,
    input  wire logic [NUM_CH*NUM_MATCH-1:0]   MATCH_IRQ_ENABLE,
    input  wire logic [NUM_CH-1:0]             OVERFLOW_IRQ_ENABLE,
    input  wire logic [NUM_CH-1:0]             UNDERFLOW_IRQ_ENABLE,
    input  wire logic [NUM_CH-1:0]             CONVERSION_TRIGGER_ENABLE,
    // Transfer engine
    input  wire logic [NUM_CH*NUM_MATCH-1:0]   XFER_ENABLE,
    input  wire logic [NUM_CH*NUM_MATCH-1:0]   XFER_DONE,
    // Capture trigger selects
    input  wire logic                          CH0B_CAP_SEL_CH1CLK,
    input  wire logic                          CH1_CAP_SEL_CH0AC,
    // Outputs
    output logic      [NUM_PHASE*CNT_W-1:0]    UP_DOWN_COUNTER,
    output logic      [NUM_PHASE-1:0]          COUNT_DIRECTION_FLAG,
    output logic      [NUM_CH*NUM_MATCH-1:0]   MATCH_CAPTURE_FLAG,
    output logic      [NUM_CH-1:0]             OVERFLOW_FLAG,
    output logic      [NUM_CH-1:0]             UNDERFLOW_FLAG,
    output logic      [NUM_CH*NUM_MATCH-1:0]   MATCH_IRQ,
    output logic      [NUM_CH-1:0]             OVERFLOW_IRQ,
    output logic      [NUM_CH-1:0]             UNDERFLOW_IRQ,
    output logic      [NUM_CH*NUM_MATCH-1:0]   XFER_REQ,
    output logic      [NUM_CH-1:0]             CONV_START_REQ,
    output logic      [NUM_CH*3-1:0]           IRQ_PRIO_SRC,
    output logic                               CH0B_CAPTURE_TRIG,
    output logic      [1:0]                    CH1_CAPTURE_TRIG
);

    // ************************************************************
    // Phase decoders
    // ************************************************************
    logic [NUM_PHASE-1:0] ph_ovf;
    logic [NUM_PHASE-1:0] ph_unf;
    logic [NUM_PHASE-1:0] ph_clk;
    logic [NUM_CH-1:0]    ovf_set;
    logic [NUM_CH-1:0]    unf_set;
    logic [NUM_CH-1:0]    mode_on;

    // Phase index to channel: 0->1, 1->2, 2->4, 3->5
    function automatic int ph_ch(input int i);
        ph_ch = (i < 2) ? i + 1 : i + 2;
    endfunction

    genvar gp;
    generate
        for (gp = 0; gp < NUM_PHASE; gp++) begin : g_ph
            localparam int CH = ph_ch(gp);
            logic pa;
            logic pb;

            assign pa = PAIR1_CH[CH] ? PHASE_A_INPUT_P1 : PHASE_A_INPUT_P2;
            assign pb = PAIR1_CH[CH] ? PHASE_B_INPUT_P1 : PHASE_B_INPUT_P2;

            qcil_phase_dec u_dec (
                .clk      (MCLK),
                .arst_n   (ARST_N),
                .pha      (pa),
                .phb      (pb),
                .mode     (PHASE_MODE[gp*2 +: 2]),
                .count    (UP_DOWN_COUNTER[gp*CNT_W +: CNT_W]),
                .dir_down (COUNT_DIRECTION_FLAG[gp]),
                .ovf_evt  (ph_ovf[gp]),
                .unf_evt  (ph_unf[gp]),
                .clk_evt  (ph_clk[gp])
            );
        end
    endgenerate

    // ************************************************************
    // Overflow / underflow sources per channel
    // ************************************************************
    genvar gc;
    generate
        for (gc = 0; gc < NUM_CH; gc++) begin : g_ch
            if (gc == 0 || gc == 3) begin : g_np
                assign mode_on[gc] = 1'b0;
                assign ovf_set[gc] = OVF_EVT[gc];
                assign unf_set[gc] = 1'b0;
            end else begin : g_p
                localparam int PI = (gc < 3) ? gc - 1 : gc - 2;
                assign mode_on[gc] = (PHASE_MODE[PI*2 +: 2] != 2'h0);
                // Phase mode overrides the unit's own wrap events
                assign ovf_set[gc] = mode_on[gc] ? ph_ovf[PI] : OVF_EVT[gc];
                assign unf_set[gc] = mode_on[gc] ? ph_unf[PI] : UNF_EVT[gc];
            end

            qcil_flag u_ovf (
                .clk     (MCLK),
                .arst_n  (ARST_N),
                .set_evt (ovf_set[gc]),
                .clr     (OVF_FLAG_CLR[gc]),
                .en      (OVERFLOW_IRQ_ENABLE[gc]),
                .flag    (OVERFLOW_FLAG[gc]),
                .req     (OVERFLOW_IRQ[gc])
            );

            if (UNDF_PRESENT[gc]) begin : g_unf
                qcil_flag u_unf (
                    .clk     (MCLK),
                    .arst_n  (ARST_N),
                    .set_evt (unf_set[gc]),
                    .clr     (UNF_FLAG_CLR[gc]),
                    .en      (UNDERFLOW_IRQ_ENABLE[gc]),
                    .flag    (UNDERFLOW_FLAG[gc]),
                    .req     (UNDERFLOW_IRQ[gc])
                );
            end else begin : g_nounf
                assign UNDERFLOW_FLAG[gc] = 1'b0;
                assign UNDERFLOW_IRQ[gc]  = 1'b0;
            end
        end
    endgenerate

    // ************************************************************
    // Match sources, transfer requests
    // ************************************************************
    genvar gm;
    generate
        for (gm = 0; gm < NUM_CH*NUM_MATCH; gm++) begin : g_m
            if (MATCH_PRESENT[gm]) begin : g_on
                logic xreq;
                assign xreq = MATCH_CAPTURE_FLAG[gm] & MATCH_IRQ_ENABLE[gm] & XFER_ENABLE[gm];
                // Transfer completion clears the source flag
                qcil_flag u_m (
                    .clk     (MCLK),
                    .arst_n  (ARST_N),
                    .set_evt (MATCH_EVT[gm]),
                    .clr     (MATCH_FLAG_CLR[gm] | (xreq & XFER_DONE[gm])),
                    .en      (MATCH_IRQ_ENABLE[gm] & ~XFER_ENABLE[gm]),
                    .flag    (MATCH_CAPTURE_FLAG[gm]),
                    .req     (MATCH_IRQ[gm])
                );
                assign XFER_REQ[gm] = xreq;
            end else begin : g_off
                assign MATCH_CAPTURE_FLAG[gm] = 1'b0;
                assign MATCH_IRQ[gm]          = 1'b0;
                assign XFER_REQ[gm]           = 1'b0;
            end
        end
    endgenerate

    // ************************************************************
    // Conversion start and fixed intra-channel priority
    // ************************************************************
    logic [NUM_CH-1:0] flag_a_prev_q;
    logic [NUM_CH-1:0] flag_a;

    generate
        for (gc = 0; gc < NUM_CH; gc++) begin : g_a
            assign flag_a[gc] = MATCH_CAPTURE_FLAG[gc*NUM_MATCH + SLOT_A];
        end
    endgenerate

    // Previous register-A flag level, for set detection
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N)
            flag_a_prev_q <= 6'h00;
        else
            flag_a_prev_q <= flag_a;
    end

    // One-cycle start pulse when the A flag sets with trigger enabled
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N)
            CONV_START_REQ <= 6'h00;
        else
            CONV_START_REQ <= flag_a & ~flag_a_prev_q & CONVERSION_TRIGGER_ENABLE;
    end

    // Highest pending source per channel: 1..4 = A..D, 5 ovf, 6 unf, 0 none
    always_comb begin
        IRQ_PRIO_SRC = '0;
        for (int c = 0; c < NUM_CH; c++) begin
            if (MATCH_IRQ[c*NUM_MATCH + SLOT_A])
                IRQ_PRIO_SRC[c*3 +: 3] = 3'h1;
            else if (MATCH_IRQ[c*NUM_MATCH + SLOT_B])
                IRQ_PRIO_SRC[c*3 +: 3] = 3'h2;
            else if (MATCH_IRQ[c*NUM_MATCH + SLOT_C])
                IRQ_PRIO_SRC[c*3 +: 3] = 3'h3;
            else if (MATCH_IRQ[c*NUM_MATCH + SLOT_D])
                IRQ_PRIO_SRC[c*3 +: 3] = 3'h4;
            else if (OVERFLOW_IRQ[c])
                IRQ_PRIO_SRC[c*3 +: 3] = 3'h5;
            else if (UNDERFLOW_IRQ[c])
                IRQ_PRIO_SRC[c*3 +: 3] = 3'h6;
        end
    end

    // ************************************************************
    // Cross-channel capture triggers
    // ************************************************************
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            CH0B_CAPTURE_TRIG <= 1'b0;
            CH1_CAPTURE_TRIG  <= 2'h0;
        end else begin
            CH0B_CAPTURE_TRIG   <= CH0B_CAP_SEL_CH1CLK & ph_clk[0];
            CH1_CAPTURE_TRIG[0] <= CH1_CAP_SEL_CH0AC & MATCH_EVT[SLOT_A];
            CH1_CAPTURE_TRIG[1] <= CH1_CAP_SEL_CH0AC & MATCH_EVT[SLOT_C];
        end
    end

endmodule // qcil_top

// ==== tb/qcil_top_props.sv ====
`timescale 1ns/100ps
// ****
// Port checker for the quadrature and interrupt logic
// ****
module qcil_top_props
    import qcil_pkg::*;
(
    input wire logic                        MCLK,
    input wire logic                        ARST_N,
    input wire logic [NUM_CH*NUM_MATCH-1:0] MATCH_EVT,
    input wire logic [NUM_CH*NUM_MATCH-1:0] MATCH_FLAG_CLR,
    input wire logic [NUM_CH*NUM_MATCH-1:0] MATCH_IRQ_ENABLE,
    input wire logic [NUM_CH-1:0]           OVERFLOW_IRQ_ENABLE,
    input wire logic [NUM_CH-1:0]           UNDERFLOW_IRQ_ENABLE,
    input wire logic [NUM_CH-1:0]           CONVERSION_TRIGGER_ENABLE,
    input wire logic [NUM_CH*NUM_MATCH-1:0] XFER_ENABLE,
    input wire logic                        CH0B_CAP_SEL_CH1CLK,
    input wire logic                        CH1_CAP_SEL_CH0AC,
    input wire logic [NUM_PHASE*CNT_W-1:0]  UP_DOWN_COUNTER,
    input wire logic [NUM_CH*NUM_MATCH-1:0] MATCH_CAPTURE_FLAG,
    input wire logic [NUM_CH-1:0]           OVERFLOW_FLAG,
    input wire logic [NUM_CH-1:0]           UNDERFLOW_FLAG,
    input wire logic [NUM_CH*NUM_MATCH-1:0] MATCH_IRQ,
    input wire logic [NUM_CH-1:0]           OVERFLOW_IRQ,
    input wire logic [NUM_CH-1:0]           UNDERFLOW_IRQ,
    input wire logic [NUM_CH*NUM_MATCH-1:0] XFER_REQ,
    input wire logic [NUM_CH-1:0]           CONV_START_REQ,
    input wire logic [NUM_CH*3-1:0]         IRQ_PRIO_SRC,
    input wire logic                        CH0B_CAPTURE_TRIG,
    input wire logic [1:0]                  CH1_CAPTURE_TRIG
);
    logic [NUM_CH-1:0] a_flag;
    logic [NUM_CH-1:0] a_prev_q;
    logic [NUM_CH-1:0] conv_exp;
    logic [CNT_W-1:0]  cnt1;

    // Register-A flags gathered per channel
    always_comb
        for (int c = 0; c < NUM_CH; c++)
            a_flag[c] = MATCH_CAPTURE_FLAG[c*NUM_MATCH];
    assign conv_exp = a_flag & ~a_prev_q & CONVERSION_TRIGGER_ENABLE;
    assign cnt1     = UP_DOWN_COUNTER[CNT_W-1:0];

    // Previous register-A flags for rise detection
    always_ff @(posedge MCLK or negedge ARST_N)
        if (!ARST_N)
            a_prev_q <= '0;
        else
            a_prev_q <= a_flag;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!ARST_N);

    chk_match_set: assert property (
        1'b1 |=> (MATCH_CAPTURE_FLAG & $past(MATCH_EVT)) == ($past(MATCH_EVT) & MATCH_PRESENT))
        else $error("match flag not set");
    chk_clear_drop: assert property (
        1'b1 |=> (MATCH_CAPTURE_FLAG & $past(MATCH_FLAG_CLR) & ~$past(MATCH_EVT)) == 24'h0)
        else $error("match flag not cleared");
    chk_irq_gate: assert property (
        MATCH_IRQ == (MATCH_CAPTURE_FLAG & MATCH_IRQ_ENABLE & ~XFER_ENABLE))
        else $error("match request wrong");
    chk_xfer_route: assert property (
        XFER_REQ == (MATCH_CAPTURE_FLAG & MATCH_IRQ_ENABLE & XFER_ENABLE))
        else $error("transfer request wrong");
    chk_ovf_irq: assert property (
        OVERFLOW_IRQ == (OVERFLOW_FLAG & OVERFLOW_IRQ_ENABLE))
        else $error("overflow request wrong");
    chk_unf_irq: assert property (
        UNDERFLOW_IRQ == (UNDERFLOW_FLAG & UNDERFLOW_IRQ_ENABLE) && !UNDERFLOW_FLAG[0] && !UNDERFLOW_FLAG[3])
        else $error("underflow request wrong");
    chk_conv_start: assert property (
        1'b1 |=> CONV_START_REQ == $past(conv_exp))
        else $error("conv start wrong");
    chk_count_step: assert property (
        $changed(cnt1) |-> (cnt1 == $past(cnt1) + 16'h1) || (cnt1 == $past(cnt1) - 16'h1))
        else $error("counter jumped");
    chk_wrap_ovf: assert property (
        $past(cnt1) == 16'hFFFF && cnt1 == 16'h0000 |-> ##2 OVERFLOW_FLAG[1])
        else $error("no overflow flag");
    chk_wrap_unf: assert property (
        $past(cnt1) == 16'h0000 && cnt1 == 16'hFFFF |-> ##2 UNDERFLOW_FLAG[1])
        else $error("no underflow flag");
    chk_prio_fixed: assert property (
        MATCH_IRQ[0] |-> IRQ_PRIO_SRC[2:0] == 3'h1)
        else $error("priority wrong");
    chk_cap_ch1: assert property (
        CH1_CAP_SEL_CH0AC && MATCH_EVT[0] |=> CH1_CAPTURE_TRIG[0])
        else $error("no ch1 capture");
    chk_cap_ch0b: assert property (
        CH0B_CAPTURE_TRIG |-> $past(CH0B_CAP_SEL_CH1CLK))
        else $error("stray ch0b capture");
endmodule // qcil_top_props

// ==== tb/qcil_enc_model.sv ====
`timescale 1ns/100ps
// ****
// Encoder pins and converter start acceptance
// ****
module qcil_enc_model (
    input  wire logic       clk,
    input  wire logic [5:0] conv_req,
    input  wire logic       sel_timer,
    output logic            a1,
    output logic            b1,
    output logic            a2,
    output logic            b2,
    output int              n_conv
);
    initial begin
        {a1, b1, a2, b2} = 4'h0;
        n_conv = 0;
    end

    // Converter starts only with the timer trigger selected
    always @(posedge clk)
        if (sel_timer)
            n_conv <= n_conv + $countones(conv_req);

    // Move one pin pair, then hold well past the minimum width
    task automatic move(input int pair, input logic a, input logic b);
        if (pair == 1)
            {a1, b1} = {a, b};
        else
            {a2, b2} = {a, b};
        repeat (6) @(negedge clk);
    endtask
endmodule // qcil_enc_model

// ==== tb/qcil_top_tb.sv ====
`timescale 1ns/100ps
// ****
// Bench for the quadrature and interrupt logic
// ****
module qcil_top_tb import qcil_pkg::*;;
    logic        mclk, arst_n, sel0b, sel1, adc_sel, ctrig0, pa, pb, pres;
    wire logic   a1, b1, a2, b2;
    logic [7:0]  mode;
    logic [23:0] mevt, mclr, men, xen, xdone, mflag, mirq, xreq;
    logic [5:0]  oevt, uevt, oclr, uclr, oen, uen, ten, oflag, uflag, oirq, uirq, conv;
    logic [63:0] cnt;
    logic [17:0] prio;
    logic [3:0]  dirf, exp_dir;
    logic [1:0]  ctrig1;
    logic [15:0] exp_cnt [4];
    logic [1:0]  seq [8] = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h2, 2'h3, 2'h1, 2'h0};
    int          errors = 0, n_checks = 0, n_trig = 0, exp_trig = 0, n_conv, d;

    qcil_top i_dut (
        .MCLK(mclk), .ARST_N(arst_n), .PHASE_A_INPUT_P1(a1), .PHASE_B_INPUT_P1(b1),
        .PHASE_A_INPUT_P2(a2), .PHASE_B_INPUT_P2(b2), .PHASE_MODE(mode), .MATCH_EVT(mevt),
        .OVF_EVT(oevt), .UNF_EVT(uevt), .MATCH_FLAG_CLR(mclr), .OVF_FLAG_CLR(oclr),
        .UNF_FLAG_CLR(uclr), .MATCH_IRQ_ENABLE(men), .OVERFLOW_IRQ_ENABLE(oen),
        .UNDERFLOW_IRQ_ENABLE(uen), .CONVERSION_TRIGGER_ENABLE(ten), .XFER_ENABLE(xen),
        .XFER_DONE(xdone), .CH0B_CAP_SEL_CH1CLK(sel0b), .CH1_CAP_SEL_CH0AC(sel1),
        .UP_DOWN_COUNTER(cnt), .COUNT_DIRECTION_FLAG(dirf), .MATCH_CAPTURE_FLAG(mflag),
        .OVERFLOW_FLAG(oflag), .UNDERFLOW_FLAG(uflag), .MATCH_IRQ(mirq), .OVERFLOW_IRQ(oirq),
        .UNDERFLOW_IRQ(uirq), .XFER_REQ(xreq), .CONV_START_REQ(conv), .IRQ_PRIO_SRC(prio),
        .CH0B_CAPTURE_TRIG(ctrig0), .CH1_CAPTURE_TRIG(ctrig1)
    );

    qcil_enc_model i_enc (
        .clk(mclk), .conv_req(conv), .sel_timer(adc_sel),
        .a1(a1), .b1(b1), .a2(a2), .b2(b2), .n_conv(n_conv)
    );

    // Clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Tally capture pulses from the channel 1 count clock
    always @(posedge mclk)
        n_trig <= n_trig + int'(ctrig0 === 1'b1);

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Count step per mode: 1 up, -1 down, 0 none
    function automatic int step(int m, logic oa, logic ob, logic a, logic b);
        logic af, bf, br;
        af = oa & ~a;
        bf = ob & ~b;
        br = ~ob & b;
        case (m)
            1: return af ? (b ? 1 : -1) : 0;
            2: return (af && b) ? 1 : ((bf && a) ? -1 : 0);
            default: return (br || bf) ? ((a ^ bf) ? 1 : -1) : 0;
        endcase
    endfunction

    // Main sequence
    initial begin
        {arst_n, sel0b, sel1, adc_sel, mode, mevt, mclr, men, xen, xdone} = '0;
        {oevt, uevt, oclr, uclr, oen, uen, ten, exp_dir} = '0;
        exp_cnt = '{4{16'h0}};
        repeat (10) @(negedge mclk);
        arst_n = 1'b1;
        // Encoder passes, both pairs, reverse then forward through zero
        oen = '1;
        uen = '1;
        sel0b = 1'b1;
        for (int m = 1; m < 4; m++) begin
            mode = {4{2'(m)}};
            for (int p = 1; p < 3; p++) begin
                {pa, pb} = 2'h0;
                for (int k = 0; k < 8; k++) begin
                    d = step(m, pa, pb, seq[k][1], seq[k][0]);
                    i_enc.move(p, seq[k][1], seq[k][0]);
                    {pa, pb} = seq[k];
                    exp_trig += int'(p == 1 && d != 0);
                    for (int j = 0; j < 4; j++) begin
                        if (((j == 0 || j == 3) ? 1 : 2) == p && d != 0) begin
                            exp_cnt[j] += 16'(d);
                            exp_dir[j] = (d < 0);
                        end
                        check("count", cnt[j*16+:16], exp_cnt[j]);
                    end
                    check("direction", dirf, exp_dir);
                end
                check("ovf flags", oirq, p == 1 ? 6'h22 : 6'h14);
                check("unf flags", uirq, p == 1 ? 6'h22 : 6'h14);
                {oclr, uclr} = '1;
                @(negedge mclk);
                {oclr, uclr} = '0;
            end
        end
        check("capture pulses", n_trig, exp_trig);
        // Overflow and underflow events with phase counting off
        mode = '0;
        {oevt, uevt} = '1;
        @(negedge mclk);
        {oevt, uevt} = '0;
        check("ovf irq", oirq, 6'h3F);
        check("unf irq", uirq, 6'h36);
        check("prio both", prio, {6{3'h5}});
        oclr = '1;
        @(negedge mclk);
        oclr = '0;
        check("prio unf", prio, {3'h6, 3'h6, 3'h0, 3'h6, 3'h6, 3'h0});
        check("no xfer", xreq, 64'h0);
        uclr = '1;
        @(negedge mclk);
        uclr = '0;
        // Every match slot: disabled, enabled, routed to transfer engine
        ten = 6'h15;
        sel1 = 1'b1;
        for (int pp = 0; pp < 3; pp++) begin
            men = (pp == 0) ? '0 : '1;
            xen = (pp == 2) ? '1 : '0;
            adc_sel = (pp != 0);
            for (int i = 0; i < 24; i++) begin
                pres = (i / 4 == 0 || i / 4 == 3 || i % 4 < 2);
                mevt = 24'h1 << i;
                @(negedge mclk);
                mevt = '0;
                check("flag", mflag, 64'(pres) << i);
                check("irq", mirq, 64'(pres && pp == 1) << i);
                check("xfer req", xreq, 64'(pres && pp == 2) << i);
                check("cap ch1", ctrig1, (i == 0) ? 2'h1 : ((i == 2) ? 2'h2 : 2'h0));
                if (pp == 1) check("prio", prio[(i/4)*3+:3], pres ? 3'(i % 4 + 1) : 3'h0);
                @(negedge mclk);
                check("conv", conv, 64'(i % 4 == 0 && ten[i/4]) << (i / 4));
                xdone = (pp == 2) ? 24'h1 << i : '0;
                mclr = (pp == 2) ? '0 : 24'h1 << i;
                @(negedge mclk);
                {xdone, mclr} = '0;
                check("cleared", mflag, 64'h0);
            end
        end
        adc_sel = 1'b0;
        // Set and clear in one cycle: set wins
        {mevt, mclr} = {24'h1, 24'h1};
        @(negedge mclk);
        {mevt, mclr} = '0;
        check("set over clear", mflag, 64'h1);
        check("conv accepted", n_conv, 6);
        results();
    end
endmodule // qcil_top_tb

bind qcil_top qcil_top_props i_props (
    .MCLK(MCLK), .ARST_N(ARST_N), .MATCH_EVT(MATCH_EVT), .MATCH_FLAG_CLR(MATCH_FLAG_CLR),
    .MATCH_IRQ_ENABLE(MATCH_IRQ_ENABLE), .OVERFLOW_IRQ_ENABLE(OVERFLOW_IRQ_ENABLE),
    .UNDERFLOW_IRQ_ENABLE(UNDERFLOW_IRQ_ENABLE), .CONVERSION_TRIGGER_ENABLE(CONVERSION_TRIGGER_ENABLE),
    .XFER_ENABLE(XFER_ENABLE), .CH0B_CAP_SEL_CH1CLK(CH0B_CAP_SEL_CH1CLK),
    .CH1_CAP_SEL_CH0AC(CH1_CAP_SEL_CH0AC), .UP_DOWN_COUNTER(UP_DOWN_COUNTER),
    .MATCH_CAPTURE_FLAG(MATCH_CAPTURE_FLAG), .OVERFLOW_FLAG(OVERFLOW_FLAG), .UNDERFLOW_FLAG(UNDERFLOW_FLAG),
    .MATCH_IRQ(MATCH_IRQ), .OVERFLOW_IRQ(OVERFLOW_IRQ), .UNDERFLOW_IRQ(UNDERFLOW_IRQ), .XFER_REQ(XFER_REQ),
    .CONV_START_REQ(CONV_START_REQ), .IRQ_PRIO_SRC(IRQ_PRIO_SRC), .CH0B_CAPTURE_TRIG(CH0B_CAPTURE_TRIG),
    .CH1_CAPTURE_TRIG(CH1_CAPTURE_TRIG)
);
